// File: design/fsp_flash_status.sv
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_flash_status (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              power_cycle,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              si_in,
  input  wire logic              wp_n,
  input  wire logic              hold_n,
  output logic                   so_out,
  output logic                   so_oe_n,
  output logic [15:0]            status_word,
  output fsp_pkg::fsp_array_req_t array_req,
  output logic                   security_locked,
  output logic                   quad_mode,
  output logic                   deep_pd
);
  import fsp_pkg::*;

  localparam logic [15:0] BUSY_CYCLES = 16'(`FSP_BUSY_CYCLES);

  logic [4:0]    pins_s;
  logic          sclk_s, cs_s, si_s, wp_s, hold_s;
  logic          sclk_d, cs_d;
  logic          sclk_rise, sclk_fall, cs_fall, cs_rise, hold_act;
  logic [2:0]    bit_cnt;
  logic [2:0]    byte_cnt;
  logic [7:0]    shift_in;
  logic [7:0]    opcode;
  logic [23:0]   addr;
  logic          read_act;
  logic          read_hi;
  logic [7:0]    out_sh;
  logic [2:0]    out_cnt;
  logic          write_enable_latch, suspend_flag, qe, lb, cmp;
  logic [4:0]    bp;
  logic [1:0]    srp;
  fsp_op_state_t op_state;
  fsp_kind_t     run_kind;
  logic [15:0]   busy_cnt;
  logic          frame_ok, sr_writable;
  logic          go_set, go_clr, go_swr, go_arr, go_susp, go_res, go_dpd, go_rel;
  fsp_kind_t     arr_kind;
  logic [15:0]   next_status;
  logic [7:0]    in_byte;

  fsp_sync #(.WIDTH(5)) u_sync (
    .clock   (clock),
    .srst    (srst),
    .async_in({sclk, cs_n, si_in, wp_n, hold_n}),
    .sync_out(pins_s)
  );

  assign {sclk_s, cs_s, si_s, wp_s, hold_s} = pins_s;
  assign hold_act  = ~qe & ~hold_s;
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s & ~hold_act;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s & ~hold_act;
  assign cs_fall   = cs_d & ~cs_s;
  assign cs_rise   = ~cs_d & cs_s;
  assign in_byte   = {shift_in[6:0], si_s};

  // protected test for one address against the current protect settings
  function automatic logic prot_hit(input logic [23:0] a, input logic [4:0] bpv, input logic cmpv);
    logic [24:0] size;
    logic        hit;
    if (bpv[2:0] == 3'h7) begin
      size = `FSP_ARRAY_BYTES;
    end else if (bpv[2:0] == 3'h0) begin
      size = 25'h000_0000;
    end else if (!bpv[4]) begin
      size = `FSP_FRAC_MIN << 3'(bpv[2:0] - 3'h1);
    end else if (bpv[2]) begin
      size = `FSP_BLK_MAX;
    end else begin
      size = `FSP_BLK_MIN << 2'(bpv[1:0] - 2'h1);
    end
    if (bpv[3]) begin
      hit = ({1'b0, a} < size);
    end else begin
      hit = ({1'b0, a} >= (`FSP_ARRAY_BYTES - size));
    end
    return hit ^ cmpv;
  endfunction

  function automatic logic range_prot(input logic [23:0] a, input logic [23:0] mask,
                                      input logic [4:0] bpv, input logic cmpv);
    return prot_hit(a & ~mask, bpv, cmpv) | prot_hit(a | mask, bpv, cmpv);
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_d <= 1'b1;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d   <= cs_s;
    end
  end

  // serial input framing
  always_ff @(posedge clock) begin
    if (srst || cs_fall) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shift_in <= 8'h00;
    end else if (sclk_rise) begin
      shift_in <= in_byte;
      bit_cnt  <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      opcode <= 8'h00;
      addr   <= 24'h00_0000;
    end else if (sclk_rise && bit_cnt == 3'h7) begin
      case (byte_cnt)
        3'h0: opcode <= in_byte;
        3'h1: addr[23:16] <= in_byte;
        3'h2: addr[15:8] <= in_byte;
        3'h3: addr[7:0] <= in_byte;
        default: ;
      endcase
    end
  end

  // status read output, shifted on falling serial clock
  always_ff @(posedge clock) begin
    if (srst || cs_s) begin
      read_act <= 1'b0;
      read_hi  <= 1'b0;
      out_sh   <= 8'h00;
      out_cnt  <= 3'h0;
    end else if (sclk_rise && bit_cnt == 3'h7 && byte_cnt == 3'h0 && !deep_pd) begin
      if (in_byte == `FSP_OP_STAT_RD_LO || in_byte == `FSP_OP_STAT_RD_HI) begin
        read_act <= 1'b1;
        read_hi  <= (in_byte == `FSP_OP_STAT_RD_HI);
        out_sh   <= (in_byte == `FSP_OP_STAT_RD_HI) ? next_status[15:8] : next_status[7:0];
        out_cnt  <= 3'h0;
      end
    end else if (sclk_fall && read_act) begin
      out_cnt <= out_cnt + 3'h1;
      if (out_cnt == 3'h7) begin
        out_sh <= read_hi ? next_status[15:8] : next_status[7:0];
      end else begin
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      so_out  <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so_oe_n <= ~(read_act & ~cs_s & ~hold_act);
      if (sclk_fall && read_act) begin
        so_out <= out_sh[7];
      end
    end
  end

  // command decision at deselect
  assign frame_ok = cs_rise && bit_cnt == 3'h0 && byte_cnt != 3'h0;
  assign sr_writable = (srp == 2'h0) | ((srp == 2'h1) & (qe | wp_s));

  always_comb begin
    go_set   = 1'b0;
    go_clr   = 1'b0;
    go_swr   = 1'b0;
    go_arr   = 1'b0;
    go_susp  = 1'b0;
    go_res   = 1'b0;
    go_dpd   = 1'b0;
    go_rel   = 1'b0;
    arr_kind = FSP_ARR_PROG;
    if (frame_ok) begin
      if (deep_pd) begin
        go_rel = (opcode == `FSP_OP_PWR_UP);
      end else if (op_state == FSP_OP_RUN) begin
        go_susp = (opcode == `FSP_OP_SUSPEND) && (run_kind != FSP_ARR_STATUS);
      end else if (opcode == `FSP_OP_LATCH_SET) begin
        go_set = (byte_cnt == 3'h1);
      end else if (opcode == `FSP_OP_LATCH_CLR) begin
        go_clr = (byte_cnt == 3'h1);
      end else if (opcode == `FSP_OP_RESUME) begin
        go_res = (op_state == FSP_OP_SUSP);
      end else if (opcode == `FSP_OP_PWR_DOWN) begin
        go_dpd = (byte_cnt == 3'h1);
      end else if (write_enable_latch && op_state == FSP_OP_IDLE) begin
        if (opcode == `FSP_OP_STAT_WR) begin
          go_swr = (byte_cnt >= `FSP_LEN_SWR_LO) && sr_writable;
        end else if (opcode == `FSP_OP_PAGE_PROG || opcode == `FSP_OP_QUAD_PROG) begin
          arr_kind = FSP_ARR_PROG;
          go_arr   = (byte_cnt >= `FSP_LEN_PROG) && !prot_hit(addr, bp, cmp);
        end else if (opcode == `FSP_OP_SECT_ERASE) begin
          arr_kind = FSP_ARR_SECT;
          go_arr   = (byte_cnt == `FSP_LEN_ADDR) && !range_prot(addr, `FSP_MASK_4K, bp, cmp);
        end else if (opcode == `FSP_OP_BLK32) begin
          arr_kind = FSP_ARR_BLK32;
          go_arr   = (byte_cnt == `FSP_LEN_ADDR) && !range_prot(addr, `FSP_MASK_32K, bp, cmp);
        end else if (opcode == `FSP_OP_BLK64) begin
          arr_kind = FSP_ARR_BLK64;
          go_arr   = (byte_cnt == `FSP_LEN_ADDR) && !range_prot(addr, `FSP_MASK_64K, bp, cmp);
        end else if (opcode == `FSP_OP_CHIP_A || opcode == `FSP_OP_CHIP_B) begin
          arr_kind = FSP_ARR_CHIP;
          go_arr   = (byte_cnt == 3'h1) && (bp[2:0] == 3'h0);
        end else if (opcode == `FSP_OP_SEC_ERASE) begin
          arr_kind = FSP_ARR_SEC_ERASE;
          go_arr   = (byte_cnt == `FSP_LEN_ADDR) && !lb;
        end else if (opcode == `FSP_OP_SEC_PROG) begin
          arr_kind = FSP_ARR_SEC_PROG;
          go_arr   = (byte_cnt >= `FSP_LEN_PROG) && !lb;
        end
      end
    end
  end

  // write enable latch
  always_ff @(posedge clock) begin
    if (srst || power_cycle) begin
      write_enable_latch <= 1'b0;
    end else if (go_set) begin
      write_enable_latch <= 1'b1;
    end else if (go_clr || go_swr || go_arr) begin
      write_enable_latch <= 1'b0;
    end
  end

  // non-volatile status fields
  always_ff @(posedge clock) begin
    if (srst) begin
      bp  <= `FSP_BP_RST;
      srp <= `FSP_SRP_RST;
      qe  <= 1'b0;
      lb  <= 1'b0;
      cmp <= 1'b0;
    end else if (power_cycle) begin
      if (srp == 2'h2) begin
        srp <= `FSP_SRP_RST;
      end
    end else if (go_swr) begin
      // low status byte sits in addr[23:16], high byte in addr[15:8]
      bp     <= addr[`FSP_BIT_BP_HI + 16:`FSP_BIT_BP_LO + 16];
      srp[0] <= addr[`FSP_BIT_SRP0 + 16];
      if (byte_cnt >= `FSP_LEN_SWR_HI) begin
        srp[1] <= addr[`FSP_BIT_SRP1];
        qe     <= addr[`FSP_BIT_QE];
        lb     <= lb | addr[`FSP_BIT_LB];
        cmp    <= addr[`FSP_BIT_CMP];
      end
    end
  end

  // internal operation sequencing
  always_ff @(posedge clock) begin
    if (srst || power_cycle) begin
      op_state <= FSP_OP_IDLE;
      run_kind <= FSP_ARR_STATUS;
      busy_cnt <= 16'h0000;
    end else begin
      case (op_state)
        FSP_OP_IDLE: begin
          if (go_swr || go_arr) begin
            op_state <= FSP_OP_RUN;
            run_kind <= go_swr ? FSP_ARR_STATUS : arr_kind;
            busy_cnt <= BUSY_CYCLES;
          end
        end
        FSP_OP_RUN: begin
          if (go_susp) begin
            op_state <= FSP_OP_SUSP;
          end else if (busy_cnt == 16'h0001) begin
            op_state <= FSP_OP_IDLE;
            busy_cnt <= 16'h0000;
          end else begin
            busy_cnt <= busy_cnt - 16'h0001;
          end
        end
        FSP_OP_SUSP: begin
          if (go_res) begin
            op_state <= FSP_OP_RUN;
          end
        end
        default: op_state <= FSP_OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst || power_cycle) begin
      suspend_flag <= 1'b0;
    end else if (go_susp) begin
      suspend_flag <= 1'b1;
    end else if (go_res) begin
      suspend_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || power_cycle) begin
      deep_pd <= 1'b0;
    end else if (go_dpd) begin
      deep_pd <= 1'b1;
    end else if (go_rel) begin
      deep_pd <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      array_req <= '{valid: 1'b0, kind: FSP_ARR_PROG, addr: 24'h00_0000};
    end else begin
      array_req.valid <= go_arr;
      if (go_arr) begin
        array_req.kind <= arr_kind;
        array_req.addr <= addr;
      end
    end
  end

  always_comb begin
    next_status                                  = `FSP_STATUS_RST;
    next_status[`FSP_BIT_BUSY]                   = (op_state == FSP_OP_RUN);
    next_status[`FSP_BIT_WEL]                    = write_enable_latch;
    next_status[`FSP_BIT_BP_HI:`FSP_BIT_BP_LO]   = bp;
    next_status[`FSP_BIT_SRP0]                   = srp[0];
    next_status[`FSP_BIT_SRP1]                   = srp[1];
    next_status[`FSP_BIT_QE]                     = qe;
    next_status[`FSP_BIT_LB]                     = lb;
    next_status[`FSP_BIT_CMP]                    = cmp;
    next_status[`FSP_BIT_SUS]                    = suspend_flag;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      status_word     <= `FSP_STATUS_RST;
      security_locked <= 1'b0;
      quad_mode       <= 1'b0;
    end else begin
      status_word     <= next_status;
      security_locked <= lb;
      quad_mode       <= qe;
    end
  end
endmodule // fsp_flash_status

// File: design/fsp_params.svh
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// opcodes
`define FSP_OP_LATCH_SET  8'h06
`define FSP_OP_LATCH_CLR  8'h04
`define FSP_OP_STAT_RD_LO 8'h05
`define FSP_OP_STAT_RD_HI 8'h35
`define FSP_OP_STAT_WR    8'h01
`define FSP_OP_PAGE_PROG  8'h02
`define FSP_OP_QUAD_PROG  8'h32
`define FSP_OP_SECT_ERASE 8'h20
`define FSP_OP_BLK32      8'h52
`define FSP_OP_BLK64      8'hD8
`define FSP_OP_CHIP_A     8'h60
`define FSP_OP_CHIP_B     8'hC7
`define FSP_OP_SUSPEND    8'h75
`define FSP_OP_RESUME     8'h7A
`define FSP_OP_PWR_DOWN   8'hB9
`define FSP_OP_PWR_UP     8'hAB
`define FSP_OP_SEC_ERASE  8'h44
`define FSP_OP_SEC_PROG   8'h42

// status word field positions
`define FSP_BIT_BUSY  0
`define FSP_BIT_WEL   1
`define FSP_BIT_BP_LO 2
`define FSP_BIT_BP_HI 6
`define FSP_BIT_SRP0  7
`define FSP_BIT_SRP1  8
`define FSP_BIT_QE    9
`define FSP_BIT_LB    10
`define FSP_BIT_CMP   14
`define FSP_BIT_SUS   15

// reset values
`define FSP_STATUS_RST 16'h0000
`define FSP_BP_RST     5'h00
`define FSP_SRP_RST    2'h0

// array geometry for protection decode
`define FSP_ARRAY_BYTES 25'h100_0000
`define FSP_FRAC_MIN    25'h004_0000
`define FSP_BLK_MIN     25'h000_1000
`define FSP_BLK_MAX     25'h000_8000
`define FSP_MASK_4K     24'h00_0FFF
`define FSP_MASK_32K    24'h00_7FFF
`define FSP_MASK_64K    24'h00_FFFF

// byte counts of framed commands
`define FSP_LEN_ADDR    3'h4
`define FSP_LEN_PROG    3'h5
`define FSP_LEN_SWR_LO  3'h2
`define FSP_LEN_SWR_HI  3'h3

// internal operation time
`define FSP_BUSY_NS     20000
`define FSP_CLK_MHZ     50
`define FSP_BUSY_CYCLES ((`FSP_BUSY_NS * `FSP_CLK_MHZ) / 1000)

`endif

// File: design/fsp_pkg.sv
package fsp_pkg;

  typedef enum logic [2:0] {
    FSP_ARR_PROG,
    FSP_ARR_SECT,
    FSP_ARR_BLK32,
    FSP_ARR_BLK64,
    FSP_ARR_CHIP,
    FSP_ARR_SEC_ERASE,
    FSP_ARR_SEC_PROG,
    FSP_ARR_STATUS
  } fsp_kind_t;

  typedef struct packed {
    logic      valid;
    fsp_kind_t kind;
    logic [23:0] addr;
  } fsp_array_req_t;

  typedef enum logic [1:0] {
    FSP_OP_IDLE,
    FSP_OP_RUN,
    FSP_OP_SUSP
  } fsp_op_state_t;

endpackage

// File: design/fsp_sync.sv
`timescale 1ns/1ps
module fsp_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (srst) begin
          meta[i]     <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule // fsp_sync

// File: tb/fsp_status_properties.sv
`timescale 1ns/1ps
module fsp_status_props (
  input wire logic                    clock,
  input wire logic                    srst,
  input wire logic                    power_cycle,
  input wire logic                    cs_n,
  input wire logic                    so_oe_n,
  input wire logic [15:0]             status_word,
  input wire fsp_pkg::fsp_array_req_t array_req,
  input wire logic                    security_locked
);
  import fsp_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence s_start;
    $rose(array_req.valid);
  endsequence
  sequence s_busy_hold;
    status_word[0] [*8];
  endsequence
  a_busy_start: assert property (s_start |=> status_word[0] && !status_word[1])
    else $error("busy or latch wrong after start");
  a_busy_holds: assert property (s_start |=> s_busy_hold)
    else $error("busy dropped early");
  a_latch_gate: assert property (array_req.valid |-> status_word[1])
    else $error("op started without latch");
  a_chip_gate: assert property (
    array_req.valid && array_req.kind == FSP_ARR_CHIP |-> status_word[4:2] == 3'h0)
    else $error("chip erase while protected");
  a_bp_source: assert property (
    $changed(status_word[6:2]) |-> $past(status_word[1]) && !$past(status_word[8]))
    else $error("protect bits changed illegally");
  a_pwr_clear: assert property (
    power_cycle |-> ##2 (!status_word[1] && !status_word[15] && status_word[8:7] != 2'b10))
    else $error("power cycle did not clear");
  a_oe_idle: assert property (cs_n [*6] |-> so_oe_n)
    else $error("output driven while deselected");
  a_lock_sticky: assert property (!$fell(security_locked))
    else $error("security lock cleared");
endmodule // fsp_status_props

bind fsp_flash_status fsp_status_props u_props (
  .clock(clock), .srst(srst), .power_cycle(power_cycle), .cs_n(cs_n), .so_oe_n(so_oe_n),
  .status_word(status_word), .array_req(array_req), .security_locked(security_locked)
);

// File: tb/fsp_spi_host.sv
`timescale 1ns/1ps
module fsp_spi_host (
  input wire logic clock,
  input wire logic so_out,
  output logic     sclk,
  output logic     cs_n,
  output logic     si_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si_in = 1'b0;
  end
  // one framed transfer, clock idles low outside frames
  task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clock);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      sclk <= 1'b0;
      si_in <= d[n-1-i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (4) @(negedge clock);
      rd = {rd[6:0], so_out};
    end
    @(posedge clock);
    sclk <= 1'b0;
    repeat (3) @(posedge clock);
    cs_n <= 1'b1;
    si_in <= ~si_in;
    repeat (8) @(posedge clock);
  endtask
endmodule // fsp_spi_host

// File: tb/fsp_flash_status_tb.sv
`timescale 1ns/1ps
module fsp_flash_status_tb;
  import fsp_pkg::*;
  logic           clock = 1'b0;
  logic           srst = 1'b1;
  logic           power_cycle = 1'b0;
  logic           wp_n = 1'b1;
  logic           hold_n = 1'b1;
  logic           sclk, cs_n, si_in, so_out, so_oe_n, security_locked, quad_mode, deep_pd;
  logic [15:0]    status_word;
  fsp_array_req_t array_req;
  logic [7:0]     rd;
  logic [15:0]    sr;
  int             miscompares = 0;
  int             checks = 0;
  always #10 clock = ~clock;
  fsp_spi_host host (.clock(clock), .so_out(so_out), .sclk(sclk), .cs_n(cs_n), .si_in(si_in));
  fsp_flash_status dut (
    .clock(clock), .srst(srst), .power_cycle(power_cycle), .sclk(sclk), .cs_n(cs_n),
    .si_in(si_in), .wp_n(wp_n), .hold_n(hold_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .status_word(status_word), .array_req(array_req), .security_locked(security_locked),
    .quad_mode(quad_mode), .deep_pd(deep_pd)
  );
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({32'h0000_0000, op}, 8, rd);
  endtask
  task automatic ers(input logic [23:0] a);
    host.frame({16'h0020, a}, 32, rd);
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (status_word[0] !== 1'b0) begin
      n++;
      if (n > 3000) begin
        miscompares++;
        stop_test();
      end
      @(posedge clock);
    end
  endtask
  task automatic wsr(input logic [7:0] lo, input logic [7:0] hi);
    cmd(8'h06);
    host.frame({24'h00_0001, lo, hi}, 24, rd);
    idle();
  endtask
  task automatic rsr(input logic [15:0] exp);
    host.frame({24'h00_0000, 16'h0500}, 16, rd);
    sr[7:0] = rd;
    host.frame({24'h00_0000, 16'h3500}, 16, rd);
    sr[15:8] = rd;
    chk(sr, exp);
    chk(status_word, exp);
  endtask
  task automatic pwr;
    @(posedge clock);
    power_cycle <= 1'b1;
    @(posedge clock);
    power_cycle <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    chk(status_word, 16'h0000);
    rsr(16'h0000);
    cmd(8'h06);
    rsr(16'h0002);
    cmd(8'h04);
    ers(24'h00_0000);
    rsr(16'h0000);
    host.frame(40'h00_0000_0003, 7, rd);
    host.frame(40'h00_0000_000c, 9, rd);
    rsr(16'h0000);
    hold_n <= 1'b0;
    cmd(8'h06);
    hold_n <= 1'b1;
    rsr(16'h0000);
    cmd(8'hb9);
    chk({15'h0000, deep_pd}, 16'h0001);
    cmd(8'h06);
    cmd(8'hab);
    chk({15'h0000, deep_pd}, 16'h0000);
    rsr(16'h0000);
    cmd(8'h06);
    cmd(8'hc7);
    chk(status_word, 16'h0001);
    idle();
    done("latch");
    wsr(8'h04, 8'h00);
    rsr(16'h0004);
    cmd(8'h06);
    ers(24'hfc_0000);
    rsr(16'h0006);
    cmd(8'hc7);
    rsr(16'h0006);
    host.frame(40'h00_2000_0000, 36, rd);
    rsr(16'h0006);
    ers(24'h00_1000);
    chk(array_req.addr[15:0], 16'h1000);
    chk({13'h0000, array_req.kind}, {13'h0000, FSP_ARR_SECT});
    idle();
    rsr(16'h0004);
    cmd(8'h06);
    host.frame(40'h02_0000_1055, 40, rd);
    chk({13'h0000, array_req.kind}, {13'h0000, FSP_ARR_PROG});
    chk(array_req.addr[15:0], 16'h0010);
    idle();
    rsr(16'h0004);
    done("protect");
    wsr(8'h04, 8'h40);
    cmd(8'h06);
    ers(24'h00_1000);
    rsr(16'h4006);
    ers(24'hfc_0000);
    idle();
    rsr(16'h4004);
    wsr(8'h44, 8'h00);
    cmd(8'h06);
    ers(24'hff_f000);
    rsr(16'h0046);
    ers(24'hff_e000);
    idle();
    rsr(16'h0044);
    done("complement");
    wsr(8'h80, 8'h00);
    rsr(16'h0080);
    wp_n <= 1'b0;
    wsr(8'h84, 8'h00);
    rsr(16'h0082);
    wp_n <= 1'b1;
    wsr(8'h84, 8'h00);
    rsr(16'h0084);
    wsr(8'h00, 8'h01);
    wsr(8'h04, 8'h00);
    rsr(16'h0102);
    pwr();
    rsr(16'h0000);
    done("modes");
    cmd(8'h06);
    ers(24'h00_1000);
    cmd(8'h75);
    rsr(16'h8000);
    cmd(8'h7a);
    rsr(16'h0001);
    cmd(8'h75);
    pwr();
    rsr(16'h0000);
    done("suspend");
    wsr(8'h00, 8'h02);
    chk({15'h0000, quad_mode}, 16'h0001);
    hold_n <= 1'b0;
    cmd(8'h06);
    hold_n <= 1'b1;
    chk(status_word, 16'h0202);
    wsr(8'h00, 8'h06);
    chk({15'h0000, security_locked}, 16'h0001);
    wsr(8'h00, 8'h02);
    rsr(16'h0600);
    cmd(8'h06);
    host.frame({16'h0044, 24'h00_0000}, 32, rd);
    rsr(16'h0602);
    wsr(8'h80, 8'h07);
    wsr(8'h00, 8'h06);
    rsr(16'h0782);
    pwr();
    rsr(16'h0780);
    done("lock");
    stop_test();
  end
endmodule // fsp_flash_status_tb
